// ---- core/enclv_regs.svh ----
// Purpose: register map, field positions and reset values of the enclave opt-in block
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes: definitions only
`ifndef ENCLV_REGS_SVH
`define ENCLV_REGS_SVH

`define ENCLV_OFS_FCTL 8'h00
`define ENCLV_OFS_CFG 8'h04
`define ENCLV_OFS_MISC 8'h08
`define ENCLV_OFS_MAXSZ 8'h0C
`define ENCLV_OFS_ATTR0 8'h10
`define ENCLV_OFS_ATTR3 8'h1C
`define ENCLV_OFS_QLEAF 8'h20
`define ENCLV_OFS_QSUB 8'h24
`define ENCLV_OFS_QSTAT 8'h28
`define ENCLV_OFS_RES0 8'h30
`define ENCLV_OFS_RES3 8'h3C
`define ENCLV_OFS_IATT 8'h40
`define ENCLV_OFS_IRES 8'h44
`define ENCLV_OFS_SEC 8'h80
`define ENCLV_OFS_SEC_END 8'h9F

`define ENCLV_NSEC 2
`define ENCLV_FCTL_LOCK 0
`define ENCLV_FCTL_EN 18
`define ENCLV_CFG_BASE 0
`define ENCLV_CFG_EXT 1
`define ENCLV_CFG_CAP 2
`define ENCLV_CFG_OVS5 5
`define ENCLV_CFG_OVS6 6
`define ENCLV_W0_OVS5 5
`define ENCLV_W0_OVS6 6
`define ENCLV_L07_CAP 2

`define ENCLV_LEAF_FEAT 32'h0000_0007
`define ENCLV_LEAF_ENCL 32'h0000_0012
`define ENCLV_TYPE_INVALID 4'h0
`define ENCLV_TYPE_SECTION 4'h1
`define ENCLV_PROT_CI 4'h1

`define ENCLV_RST_FCTL 32'h0000_0000
`define ENCLV_RST_CFG 32'h0000_0007
`define ENCLV_RST_MISC 32'h0000_0000
`define ENCLV_RST_MAXSZ 16'h241F
`define ENCLV_RST_ATTR 32'h0000_0000

`endif

// ---- core/enclv_pkg.sv ----
// Purpose: shared types of the enclave opt-in block
// Assumes: constants live in enclv_regs.svh
// Notes: none
package enclv_pkg;

  typedef struct packed {
    logic [31:0] w3;
    logic [31:0] w2;
    logic [31:0] w1;
    logic [31:0] w0;
  } enclv_words_t;

  typedef struct packed {
    logic cap;
    logic base_ops;
    logic ext_ops;
    logic ovs5;
    logic ovs6;
    logic [31:0] misc;
    logic [7:0] max_legacy;
    logic [7:0] max_long;
    logic [127:0] attr_mask;
  } enclv_cfg_t;

  typedef struct packed {
    logic [31:0] base_lo;
    logic [31:0] base_hi;
    logic [31:0] size_lo;
    logic [31:0] size_hi;
  } enclv_sec_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic mapped;
    logic [7:0] addr;
  } enclv_aphase_t;

  typedef enum logic [1:0] {
    ENCLV_GRP_BASE,
    ENCLV_GRP_EXT,
    ENCLV_GRP_OVS_VIRT,
    ENCLV_GRP_OVS_TRACK
  } enclv_group_t;

  typedef enum logic [1:0] {
    ENCLV_EXEC_OK,
    ENCLV_FAULT_UD,
    ENCLV_FAULT_GP
  } enclv_fault_t;

endpackage

// ---- core/enclv_query.sv ----
// Purpose: capability query decode, leaf and sub-leaf to four result words
// Assumes: section entry already selected by the caller
// Notes: purely combinational
`timescale 1ns/100ps
`include "enclv_regs.svh"
module enclv_query import enclv_pkg::*; (
  input wire enclv_cfg_t cfg, // capability configuration
  input wire logic opted_in, // lock and enable both set
  input wire logic [31:0] leaf, // query leaf
  input wire logic [31:0] sub, // query sub-leaf
  input wire enclv_sec_t sec, // section entry for sub-2
  input wire logic sec_in_range, // sub-2 indexes a stored entry
  output enclv_words_t words // result words 0..3
);
  always_comb begin
    words = '0;
    if (leaf == `ENCLV_LEAF_FEAT && sub == 32'h0000_0000) begin
      words.w1[`ENCLV_L07_CAP] = cfg.cap;
    end else if (leaf == `ENCLV_LEAF_ENCL && cfg.cap) begin
      // enable bit deliberately absent from every word
      case (sub)
        32'h0000_0000: begin
          words.w0[`ENCLV_CFG_BASE] = cfg.base_ops;
          words.w0[`ENCLV_CFG_EXT] = cfg.ext_ops;
          words.w0[`ENCLV_W0_OVS5] = cfg.ovs5;
          words.w0[`ENCLV_W0_OVS6] = cfg.ovs6;
          words.w1 = cfg.misc;
          words.w3 = {16'h0000, cfg.max_long, cfg.max_legacy};
        end
        32'h0000_0001: begin
          words = cfg.attr_mask;
        end
        default: begin
          // sections only exist once opted in; anything else is all zero
          if (opted_in && sec_in_range && sec.base_lo[3:0] == `ENCLV_TYPE_SECTION) begin
            words.w0 = {sec.base_lo[31:12], 8'h00, `ENCLV_TYPE_SECTION};
            words.w1 = {12'h000, sec.base_hi[19:0]};
            words.w2 = {sec.size_lo[31:12], 8'h00, sec.size_lo[3:0]};
            words.w3 = {12'h000, sec.size_hi[19:0]};
          end
        end
      endcase
    end
  end
endmodule

// ---- core/enclv_gate.sv ----
// Purpose: outcome of an enclave instruction attempt
// Assumes: flags come from the capability configuration
// Notes: purely combinational
`timescale 1ns/100ps
module enclv_gate import enclv_pkg::*; (
  input wire enclv_cfg_t cfg, // capability configuration
  input wire logic lock, // feature-control lock
  input wire logic enable, // enclave opt-in enable
  input wire enclv_group_t group, // instruction group attempted
  output enclv_fault_t fault // resulting outcome
);
  logic supported;

  always_comb begin
    case (group)
      ENCLV_GRP_BASE: supported = cfg.base_ops;
      ENCLV_GRP_EXT: supported = cfg.ext_ops;
      ENCLV_GRP_OVS_VIRT: supported = cfg.ovs5;
      ENCLV_GRP_OVS_TRACK: supported = cfg.ovs6;
      default: supported = 1'b0;
    endcase
    // undefined opcode outranks the opt-in check
    if (!cfg.cap || !supported) begin
      fault = ENCLV_FAULT_UD;
    end else if (!lock || !enable) begin
      fault = ENCLV_FAULT_GP;
    end else begin
      fault = ENCLV_EXEC_OK;
    end
  end
endmodule

// ---- core/enclv_top.sv ----
// Purpose: enclave opt-in gating and capability enumeration behind an AHB-Lite slave
// Assumes: one hardware thread per instance; single word transfers
// Notes: zero wait state slave, always OKAY
`timescale 1ns/100ps
`include "enclv_regs.svh"
module enclv_top import enclv_pkg::*; (
  input wire logic clock, // core clock, 10 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always OKAY
  output logic [31:0] hrdata, // read data
  output logic enclave_opted_in // lock and enable both set
);
  enclv_aphase_t aphase;
  enclv_aphase_t next_aphase;
  logic [31:0] hrdata_q;
  logic [31:0] next_hrdata;

  logic fctl_lock;
  logic fctl_en;
  logic next_fctl_lock;
  logic next_fctl_en;
  logic opted;
  logic next_opted;

  // every piece of enumeration state lives in this instance alone: one hardware thread
  enclv_cfg_t cfg;
  enclv_cfg_t next_cfg;
  enclv_sec_t sec_mem [`ENCLV_NSEC];
  enclv_sec_t next_sec_mem [`ENCLV_NSEC];

  logic [31:0] qleaf;
  logic [31:0] next_qleaf;
  logic [31:0] qsub;
  logic [31:0] next_qsub;
  enclv_words_t qres;
  enclv_words_t next_qres;
  logic qdone;
  logic next_qdone;
  enclv_words_t q_words;
  enclv_sec_t q_sec;
  logic q_in_range;
  logic [31:0] q_idx;

  enclv_group_t igrp;
  enclv_group_t next_igrp;
  enclv_fault_t ires;
  enclv_fault_t next_ires;
  enclv_fault_t gate_fault;

  logic wr_go;
  logic [7:0] wr_ofs;

  function automatic logic in_sec(input logic [7:0] ofs);
    in_sec = ofs >= `ENCLV_OFS_SEC && ofs <= `ENCLV_OFS_SEC_END;
  endfunction

  function automatic logic [31:0] attr_word(input logic [127:0] mask, input logic [1:0] n);
    attr_word = mask[n * 32 +: 32];
  endfunction

  // bus address phase; only aligned word writes are acted on
  always_comb begin
    next_aphase = aphase;
    if (hready) begin
      next_aphase.valid = hsel && htrans[1];
      next_aphase.write = hwrite;
      next_aphase.word = hsize == 3'h2 && haddr[1:0] == 2'h0;
      next_aphase.mapped = haddr[31:8] == 24'h00_0000;
      next_aphase.addr = haddr[7:0];
    end
  end

  assign wr_go = aphase.valid && aphase.write && aphase.word && aphase.mapped;
  assign wr_ofs = aphase.addr;

  // feature-control: writable until locked, enable shares the lock semantics
  always_comb begin
    next_fctl_lock = fctl_lock;
    next_fctl_en = fctl_en;
    if (wr_go && wr_ofs == `ENCLV_OFS_FCTL && !fctl_lock) begin
      next_fctl_lock = hwdata[`ENCLV_FCTL_LOCK];
      next_fctl_en = hwdata[`ENCLV_FCTL_EN];
    end
    next_opted = next_fctl_lock && next_fctl_en;
  end

  // configuration written by firmware; reset values give a usable device
  always_comb begin
    next_cfg = cfg;
    for (int i = 0; i < `ENCLV_NSEC; i++) begin
      next_sec_mem[i] = sec_mem[i];
    end
    if (wr_go) begin
      case (wr_ofs)
        `ENCLV_OFS_CFG: begin
          next_cfg.base_ops = hwdata[`ENCLV_CFG_BASE];
          next_cfg.ext_ops = hwdata[`ENCLV_CFG_EXT];
          next_cfg.cap = hwdata[`ENCLV_CFG_CAP];
          next_cfg.ovs5 = hwdata[`ENCLV_CFG_OVS5];
          next_cfg.ovs6 = hwdata[`ENCLV_CFG_OVS6];
        end
        `ENCLV_OFS_MISC: next_cfg.misc = hwdata;
        `ENCLV_OFS_MAXSZ: begin
          next_cfg.max_legacy = hwdata[7:0];
          next_cfg.max_long = hwdata[15:8];
        end
        default: begin
          if (wr_ofs >= `ENCLV_OFS_ATTR0 && wr_ofs <= `ENCLV_OFS_ATTR3) begin
            next_cfg.attr_mask[wr_ofs[3:2] * 32 +: 32] = hwdata;
          end
          if (in_sec(wr_ofs)) begin
            case (wr_ofs[3:2])
              2'h0: next_sec_mem[wr_ofs[4]].base_lo = hwdata;
              2'h1: next_sec_mem[wr_ofs[4]].base_hi = hwdata;
              2'h2: next_sec_mem[wr_ofs[4]].size_lo = hwdata;
              default: next_sec_mem[wr_ofs[4]].size_hi = hwdata;
            endcase
          end
        end
      endcase
    end
  end

  // query: writing the sub-leaf launches it and latches all four words at once
  // sub-leaf 0, sub-leaf 1 and the two stored sections fill sub-leaves 0 to 3
  assign q_idx = qsub - 32'h0000_0002;
  assign q_in_range = qsub >= 32'h0000_0002 && q_idx < `ENCLV_NSEC;
  assign q_sec = sec_mem[q_idx[0]];

  enclv_query u_query (
    .cfg(cfg),
    .opted_in(opted),
    .leaf(qleaf),
    .sub(qsub),
    .sec(q_sec),
    .sec_in_range(q_in_range),
    .words(q_words)
  );

  always_comb begin
    next_qleaf = qleaf;
    next_qsub = qsub;
    next_qres = qres;
    next_qdone = qdone;
    if (wr_go && wr_ofs == `ENCLV_OFS_QLEAF) begin
      next_qleaf = hwdata;
      next_qdone = 1'b0;
    end
    if (wr_go && wr_ofs == `ENCLV_OFS_QSUB) begin
      next_qsub = hwdata;
      next_qdone = 1'b0;
    end
    // the answer follows one cycle after the sub-leaf write
    if (!qdone && !(wr_go && (wr_ofs == `ENCLV_OFS_QSUB || wr_ofs == `ENCLV_OFS_QLEAF))) begin
      next_qres = q_words;
      next_qdone = 1'b1;
    end
  end

  // instruction attempt: the group written is judged against the opt-in state
  enclv_gate u_gate (
    .cfg(cfg),
    .lock(fctl_lock),
    .enable(fctl_en),
    .group(igrp),
    .fault(gate_fault)
  );

  always_comb begin
    next_igrp = igrp;
    next_ires = gate_fault;
    if (wr_go && wr_ofs == `ENCLV_OFS_IATT) begin
      next_igrp = enclv_group_t'(hwdata[1:0]);
    end
  end

  // read data is prepared in the address phase so the data phase needs no wait
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
      case (haddr[7:0])
        `ENCLV_OFS_FCTL: begin
          next_hrdata[`ENCLV_FCTL_LOCK] = fctl_lock;
          next_hrdata[`ENCLV_FCTL_EN] = fctl_en;
        end
        `ENCLV_OFS_CFG: begin
          next_hrdata[`ENCLV_CFG_BASE] = cfg.base_ops;
          next_hrdata[`ENCLV_CFG_EXT] = cfg.ext_ops;
          next_hrdata[`ENCLV_CFG_CAP] = cfg.cap;
          next_hrdata[`ENCLV_CFG_OVS5] = cfg.ovs5;
          next_hrdata[`ENCLV_CFG_OVS6] = cfg.ovs6;
        end
        `ENCLV_OFS_MISC: next_hrdata = cfg.misc;
        `ENCLV_OFS_MAXSZ: next_hrdata = {16'h0000, cfg.max_long, cfg.max_legacy};
        `ENCLV_OFS_QLEAF: next_hrdata = qleaf;
        `ENCLV_OFS_QSUB: next_hrdata = qsub;
        `ENCLV_OFS_QSTAT: next_hrdata = {30'h0000_0000, opted, qdone};
        `ENCLV_OFS_IATT: next_hrdata = {30'h0000_0000, igrp};
        `ENCLV_OFS_IRES: next_hrdata = {30'h0000_0000, ires};
        default: begin
          if (haddr[7:0] >= `ENCLV_OFS_ATTR0 && haddr[7:0] <= `ENCLV_OFS_ATTR3) begin
            next_hrdata = attr_word(cfg.attr_mask, haddr[3:2]);
          end
          if (haddr[7:0] >= `ENCLV_OFS_RES0 && haddr[7:0] <= `ENCLV_OFS_RES3) begin
            next_hrdata = attr_word(qres, haddr[3:2]);
          end
          if (in_sec(haddr[7:0])) begin
            case (haddr[3:2])
              2'h0: next_hrdata = sec_mem[haddr[4]].base_lo;
              2'h1: next_hrdata = sec_mem[haddr[4]].base_hi;
              2'h2: next_hrdata = sec_mem[haddr[4]].size_lo;
              default: next_hrdata = sec_mem[haddr[4]].size_hi;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aphase <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      fctl_lock <= 1'(`ENCLV_RST_FCTL >> `ENCLV_FCTL_LOCK);
      fctl_en <= 1'(`ENCLV_RST_FCTL >> `ENCLV_FCTL_EN);
      opted <= 1'b0;
      enclave_opted_in <= 1'b0;
      cfg.cap <= 1'(`ENCLV_RST_CFG >> `ENCLV_CFG_CAP);
      cfg.base_ops <= 1'(`ENCLV_RST_CFG >> `ENCLV_CFG_BASE);
      cfg.ext_ops <= 1'(`ENCLV_RST_CFG >> `ENCLV_CFG_EXT);
      cfg.ovs5 <= 1'(`ENCLV_RST_CFG >> `ENCLV_CFG_OVS5);
      cfg.ovs6 <= 1'(`ENCLV_RST_CFG >> `ENCLV_CFG_OVS6);
      cfg.misc <= `ENCLV_RST_MISC;
      cfg.max_legacy <= 8'(`ENCLV_RST_MAXSZ);
      cfg.max_long <= 8'(`ENCLV_RST_MAXSZ >> 8);
      cfg.attr_mask <= {4{`ENCLV_RST_ATTR}};
      for (int i = 0; i < `ENCLV_NSEC; i++) begin
        sec_mem[i] <= '0;
      end
      qleaf <= 32'h0000_0000;
      qsub <= 32'h0000_0000;
      qres <= '0;
      qdone <= 1'b0;
      igrp <= ENCLV_GRP_BASE;
      ires <= ENCLV_FAULT_UD;
    end else begin
      aphase <= next_aphase;
      hrdata_q <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      fctl_lock <= next_fctl_lock;
      fctl_en <= next_fctl_en;
      opted <= next_opted;
      enclave_opted_in <= next_opted;
      cfg <= next_cfg;
      for (int i = 0; i < `ENCLV_NSEC; i++) begin
        sec_mem[i] <= next_sec_mem[i];
      end
      qleaf <= next_qleaf;
      qsub <= next_qsub;
      qres <= next_qres;
      qdone <= next_qdone;
      igrp <= next_igrp;
      ires <= next_ires;
    end
  end

  assign hrdata = hrdata_q;
endmodule

// ---- verification/enclv_top_properties.sv ----
// Purpose: port checker of the enclave opt-in block
// Assumes: hready tied to hreadyout
// Notes: bound to enclv_top
`timescale 1ns/100ps
module enclv_top_properties (
  input wire logic clock, // core clock
  input wire logic rst_b, // async reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // direction
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic enclave_opted_in // opted in
);
  logic rd_dp;
  logic wr_dp;
  logic fctl_set;
  logic [31:0] a_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      fctl_set <= 1'b0;
      a_q <= 32'h0;
    end else begin
      rd_dp <= hsel && htrans[1] && hready && !hwrite;
      wr_dp <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
      fctl_set <= wr_dp && a_q == 32'h0 && hwdata[0] && hwdata[18];
      if (hsel && htrans[1] && hready) begin
        a_q <= haddr;
      end
    end
  end
  a_ready_high: assert property (@(posedge clock) disable iff (!rst_b)
    hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (@(posedge clock) disable iff (!rst_b)
    hresp == 1'b0) else $error("hresp not okay");
  a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !rd_dp |-> hrdata == 32'h0) else $error("hrdata outside read");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_b)
    rd_dp && (a_q[31:8] != 24'h0 || a_q[7:0] == 8'h2C) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_optin_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    enclave_opted_in |=> enclave_opted_in) else $error("opt-in dropped");
  a_optin_cause: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(enclave_opted_in) |-> fctl_set || $past(fctl_set))
    else $error("opt-in without lock and enable write");
  a_gate_code: assert property (@(posedge clock) disable iff (!rst_b)
    rd_dp && a_q == 32'h44 |-> hrdata[31:2] == 30'h0 && hrdata[1:0] != 2'h3)
    else $error("bad outcome code");
  a_gate_exec: assert property (@(posedge clock) disable iff (!rst_b)
    rd_dp && a_q == 32'h44 && hrdata[1:0] == 2'h0 |-> ##[0:1] enclave_opted_in)
    else $error("execute while not opted in");
endmodule
bind enclv_top enclv_top_properties i_enclv_top_properties (.clock(clock), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .enclave_opted_in(enclave_opted_in));

// ---- verification/enclv_host.sv ----
// Purpose: firmware side, an AHB-Lite master issuing single word transfers
// Assumes: one slave, its hreadyout is hready
// Notes: released lines show inverted values so stale data never matches
`timescale 1ns/100ps
module enclv_host (
  input wire logic clock, // core clock
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  output logic hsel, // select
  output logic [31:0] haddr, // address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // direction
  output logic [2:0] hsize, // size
  output logic [31:0] hwdata // write data
);
  logic hung = 1'b0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one hardware thread: results are never shared with another instance
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwrite <= ~w;
    hwdata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 64);
    r = hrdata;
    hung = (n >= 64);
  endtask
endmodule

// ---- verification/enclv_top_tb.sv ----
// Purpose: self-checking bench of the enclave opt-in block
// Assumes: zero wait state slave
// Notes: expected words come from the model state below
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module enclv_top_tb;
  logic clock;
  logic rst_b = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, enclave_opted_in;
  logic [31:0] haddr, hwdata, hrdata, r, seed, q0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] m_cfg, m_misc, m_max;
  logic [31:0] m_attr [4];
  logic [31:0] m_sec [8];
  logic m_opt;
  int error_cnt = 0;
  int num_checks = 0;
  int nz, s;
  assign hready = hreadyout;
  enclv_top i_enclv_top (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .enclave_opted_in(enclave_opted_in));
  enclv_host i_enclv_host (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    i_enclv_host.xfer(w, a, d, r);
    if (i_enclv_host.hung) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // enable bit never enters the words
  function automatic logic [127:0] expq(input logic [31:0] lf, input logic [31:0] sb);
    logic [127:0] w;
    int i;
    w = '0;
    i = 4 * (sb - 2);
    if (lf == 32'h7 && sb == 32'h0) w[34] = m_cfg[2];
    else if (lf == 32'h12 && m_cfg[2]) begin
      if (sb == 32'h0) w = {16'h0, m_max[15:0], 32'h0, m_misc, 25'h0, m_cfg[6:5], 3'h0,
        m_cfg[1:0]};
      else if (sb == 32'h1) w = {m_attr[3], m_attr[2], m_attr[1], m_attr[0]};
      else if (sb < 4 && m_opt && m_sec[i][3:0] == 4'h1) w = {12'h0, m_sec[i+3][19:0],
        m_sec[i+2][31:12], 8'h0, m_sec[i+2][3:0], 12'h0, m_sec[i+1][19:0],
        m_sec[i][31:12], 12'h1};
    end
    return w;
  endfunction
  task automatic query(input logic [31:0] lf, input logic [31:0] sb);
    logic [127:0] e;
    logic any;
    int n;
    xf(1'b1, 32'h20, lf);
    xf(1'b1, 32'h24, sb);
    n = 0;
    do begin
      xf(1'b0, 32'h28, 32'h0);
      n++;
    end while (r[0] !== 1'b1 && n < 20);
    `CHK(r[0], 1'b1)
    if (r[0] !== 1'b1) stop_test();
    e = expq(lf, sb);
    any = 1'b0;
    for (int k = 0; k < 4; k++) begin
      xf(1'b0, 32'h30 + 4 * k, 32'h0);
      `CHK(r, e[32*k +: 32])
      if (k == 0) q0 = r;
      if (r != 32'h0) any = 1'b1;
    end
    if (any) nz++;
  endtask
  function automatic logic [1:0] gexp(input int g);
    logic f;
    f = (g == 0) ? m_cfg[0] : (g == 1) ? m_cfg[1] : (g == 2) ? m_cfg[5] : m_cfg[6];
    if (!m_cfg[2] || !f) return 2'h1;
    if (!m_opt) return 2'h2;
    return 2'h0;
  endfunction
  task automatic gates();
    for (int g = 0; g < 4; g++) begin
      xf(1'b1, 32'h40, g);
      xf(1'b0, 32'h44, 32'h0);
      `CHK(r[1:0], gexp(g))
    end
  endtask
  initial begin
    seed = 32'h87D4EDDC;
    m_cfg = 32'h7;
    m_misc = 32'h0;
    m_max = 32'h241F;
    m_opt = 1'b0;
    nz = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    xf(1'b0, 32'h0, 32'h0);
    `CHK(r, 32'h0)
    xf(1'b0, 32'h4, 32'h0);
    `CHK(r, 32'h7)
    xf(1'b0, 32'h0C, 32'h0);
    `CHK(r, 32'h241F)
    xf(1'b0, 32'h2C, 32'h0);
    `CHK(r, 32'h0)
    m_misc = rnd();
    xf(1'b1, 32'h8, m_misc);
    m_max = rnd() & 32'hFFFF;
    xf(1'b1, 32'h0C, m_max);
    m_cfg = 32'h27;
    xf(1'b1, 32'h4, m_cfg);
    for (int k = 0; k < 4; k++) begin
      m_attr[k] = rnd();
      xf(1'b1, 32'h10 + 4 * k, m_attr[k]);
    end
    for (int k = 0; k < 8; k++) begin
      m_sec[k] = rnd();
      if (k % 2 == 0) m_sec[k][3:0] = 4'h1;
      xf(1'b1, 32'h80 + 4 * k, m_sec[k]);
    end
    query(32'h7, 32'h0);
    for (int k = 0; k < 3; k++) query(32'h12, k);
    xf(1'b1, 32'h0, 32'h0004_0000);
    gates();
    xf(1'b1, 32'h0, 32'h0004_0001);
    xf(1'b0, 32'h28, 32'h0);
    m_opt = 1'b1;
    `CHK(enclave_opted_in, 1'b1)
    `CHK(r[1], 1'b1)
    gates();
    xf(1'b1, 32'h0, 32'h0);
    xf(1'b0, 32'h0, 32'h0);
    `CHK(r, 32'h0004_0001)
    nz = 0;
    query(32'h12, 32'h0);
    query(32'h12, 32'h1);
    s = 2;
    // walk section sub-leaves until one reads invalid
    do begin
      query(32'h12, s);
      s++;
    end while (q0[3:0] !== 4'h0 && s < 6);
    `CHK(s, 5)
    `CHK(nz >= 3, 1'b1)
    m_cfg = 32'h23;
    xf(1'b1, 32'h4, m_cfg);
    query(32'h7, 32'h0);
    query(32'h12, 32'h0);
    gates();
    stop_test();
  end
endmodule
